// *** hdl/wdgp_pkg.sv ***
// Constants and types of the watchdog with game-port reload
package wdgp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned UNIT_SEC_S  = 1;
  localparam int unsigned SEC_CYCLES  = CLK_HZ * UNIT_SEC_S;
  localparam int unsigned MIN_SECONDS = 60;

  // ****************************************
  // Register indexes and byte addresses
  // ****************************************
  localparam logic [9:0]  IDX_GP_ACT  = 10'h030;
  localparam logic [9:0]  IDX_GP_HI   = 10'h060;
  localparam logic [9:0]  IDX_GP_LO   = 10'h061;
  localparam logic [9:0]  IDX_WD_CTL  = 10'h0fb;
  localparam logic [9:0]  IDX_WD_PIN  = 10'h0fc;
  localparam logic [9:0]  IDX_WD_VAL  = 10'h0fd;
  localparam logic [19:0] ADDR_GP_ACT = {8'h00, IDX_GP_ACT, 2'b00};
  localparam logic [19:0] ADDR_GP_HI  = {8'h00, IDX_GP_HI, 2'b00};
  localparam logic [19:0] ADDR_GP_LO  = {8'h00, IDX_GP_LO, 2'b00};
  localparam logic [19:0] ADDR_WD_CTL = {8'h00, IDX_WD_CTL, 2'b00};
  localparam logic [19:0] ADDR_WD_PIN = {8'h00, IDX_WD_PIN, 2'b00};
  localparam logic [19:0] ADDR_WD_VAL = {8'h00, IDX_WD_VAL, 2'b00};
  // I/O window: haddr[20] set, port number in haddr[17:2]
  localparam int unsigned IO_WIN_BIT  = 20;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned CTL_CIR_EN_BIT = 7;
  localparam int unsigned CTL_GP_EN_BIT  = 4;
  localparam int unsigned CTL_UNIT_BIT   = 3;
  localparam int unsigned CTL_FORCE_BIT  = 1;
  localparam int unsigned CTL_STAT_BIT   = 0;
  localparam int unsigned GP_ACT_EN_BIT  = 0;
  localparam logic [7:0]  CTL_RW_MASK    = 8'h98;
  localparam logic [7:0]  RST_GP_ACT     = 8'h00;
  localparam logic [3:0]  RST_GP_HI      = 4'h2;
  localparam logic [7:0]  RST_GP_LO      = 8'h01;
  localparam logic [7:0]  RST_WD_CTL     = 8'h00;
  localparam logic [5:0]  RST_WD_PIN     = 6'h00;
  localparam logic [7:0]  RST_WD_VAL     = 8'h00;
  localparam logic [7:0]  IO_RD_DATA     = 8'hff;

  typedef enum logic [1:0] {
    WDGP_ST_IDLE    = 2'b00,
    WDGP_ST_RUN     = 2'b01,
    WDGP_ST_EXPIRED = 2'b10
  } wdgp_state_t;

endpackage

// *** hdl/wdgp_tick_if.sv ***
// Tick carrier between watchdog core and its time base
`timescale 1ns/100ps
`default_nettype none
interface wdgp_tick_if;
  logic restart;
  logic sec_tick;
  logic min_tick;
  modport gen (input restart, output sec_tick, output min_tick);
  modport use_side (output restart, input sec_tick, input min_tick);
endinterface
`default_nettype wire

// *** hdl/wdgp_timebase.sv ***
// Second and minute tick generator for the watchdog
`timescale 1ns/100ps
`default_nettype none
module wdgp_timebase #(
  parameter int unsigned SEC_CYCLES = wdgp_pkg::SEC_CYCLES
) (
  input  wire logic  hclk,
  input  wire logic  hresetn,
  wdgp_tick_if.gen   tk
);
  import wdgp_pkg::*;

  localparam int unsigned SW = $clog2(SEC_CYCLES);

  if (SEC_CYCLES < 2) begin : g_bad_cycles
    $error("SEC_CYCLES must be at least 2");
  end

  logic [SW-1:0] sec_cnt_q, sec_cnt_d;
  logic [5:0]    min_cnt_q, min_cnt_d;
  logic          sec_q, sec_d;
  logic          min_q, min_d;

  // Restart aligns the unit to the reload so the first unit is whole
  always_comb begin
    sec_cnt_d = sec_cnt_q + SW'(1);
    min_cnt_d = min_cnt_q;
    sec_d     = 1'b0;
    min_d     = 1'b0;
    if (tk.restart) begin
      sec_cnt_d = '0;
      min_cnt_d = '0;
    end else if (sec_cnt_q == SW'(SEC_CYCLES - 1)) begin
      sec_cnt_d = '0;
      sec_d     = 1'b1;
      if (min_cnt_q == 6'(MIN_SECONDS - 1)) begin
        min_cnt_d = '0;
        min_d     = 1'b1;
      end else begin
        min_cnt_d = min_cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_cnt_q <= '0;
      min_cnt_q <= '0;
      sec_q     <= 1'b0;
      min_q     <= 1'b0;
    end else begin
      sec_cnt_q <= sec_cnt_d;
      min_cnt_q <= min_cnt_d;
      sec_q     <= sec_d;
      min_q     <= min_d;
    end
  end

  assign tk.sec_tick = sec_q;
  assign tk.min_tick = min_q;

endmodule // wdgp_timebase
`default_nettype wire

// *** hdl/wdgp_watchdog_top.sv ***
// Watchdog timer with game-port and infrared reload, AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none
module wdgp_watchdog_top #(
  parameter int unsigned SEC_CYCLES = wdgp_pkg::SEC_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        consumer_infrared_irq,
  output logic             watchdog_timer_timeout,
  output logic      [5:0]  watchdog_timer_pin_loc,
  output logic             game_port_enable,
  output logic      [15:0] game_port_base
);
  import wdgp_pkg::*;

  // A second shorter than two clocks would never let the tick counter wrap
  if (SEC_CYCLES < 2) begin : g_bad_cycles
    $error("SEC_CYCLES must be at least 2");
  end

  // ****************************************
  // Bus slave
  // ****************************************
  logic        dp_q, dp_d;
  logic        wr_q, wr_d;
  logic        io_q, io_d;
  logic [19:0] addr_q, addr_d;
  logic        rdy_q, rdy_d;
  logic [31:0] rdata_q, rdata_d;
  logic        take;
  logic [7:0]  rd_byte;

  // Registers
  logic [7:0]  gp_act_q, gp_act_d;
  logic [3:0]  gp_hi_q, gp_hi_d;
  logic [7:0]  gp_lo_q, gp_lo_d;
  logic [7:0]  ctl_q, ctl_d;
  logic        force_q, force_d;
  logic        stat_q, stat_d;
  logic [5:0]  pin_q, pin_d;
  logic [7:0]  val_q, val_d;

  // Watchdog
  wdgp_state_t state_q, state_d;
  logic [8:0]  cnt_q, cnt_d;
  logic        cir_q;
  logic        wr_evt, ctl_wr, val_wr;
  logic        cir_pulse, gp_pulse, reload, unit_tick, expire;
  logic [15:0] base_addr;

  wdgp_tick_if tk ();

  wdgp_timebase #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_timebase (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tk      (tk.gen)
  );

  // Every transfer takes one wait state, so a read never races the
  // write that went before it
  assign take = hsel & hready & htrans[1];

  always_comb begin
    case (addr_q)
      ADDR_GP_ACT: rd_byte = gp_act_q;
      ADDR_GP_HI:  rd_byte = {4'h0, gp_hi_q};
      ADDR_GP_LO:  rd_byte = gp_lo_q;
      ADDR_WD_CTL: rd_byte = {ctl_q[7], 2'b00, ctl_q[4], ctl_q[3], 1'b0, force_q, stat_q};
      ADDR_WD_PIN: rd_byte = {2'b00, pin_q};
      ADDR_WD_VAL: rd_byte = val_q;
      default:     rd_byte = 8'h00;
    endcase
    if (io_q) begin
      rd_byte = gp_act_q[GP_ACT_EN_BIT] ? IO_RD_DATA : 8'h00;
    end
  end

  always_comb begin
    dp_d    = 1'b0;
    wr_d    = wr_q;
    io_d    = io_q;
    addr_d  = addr_q;
    rdy_d   = 1'b1;
    rdata_d = rdata_q;
    if (dp_q) begin
      rdata_d = {24'h000000, rd_byte};
    end else if (take) begin
      dp_d   = 1'b1;
      rdy_d  = 1'b0;
      wr_d   = hwrite;
      io_d   = haddr[IO_WIN_BIT];
      addr_d = haddr[19:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q    <= 1'b0;
      wr_q    <= 1'b0;
      io_q    <= 1'b0;
      addr_q  <= 20'h00000;
      rdy_q   <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      dp_q    <= dp_d;
      wr_q    <= wr_d;
      io_q    <= io_d;
      addr_q  <= addr_d;
      rdy_q   <= rdy_d;
      rdata_q <= rdata_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = rdy_q;
  assign hresp     = 1'b0;

  // ****************************************
  // Register file
  // ****************************************
  assign wr_evt = dp_q & wr_q & ~io_q;
  assign ctl_wr = wr_evt & (addr_q == ADDR_WD_CTL);
  assign val_wr = wr_evt & (addr_q == ADDR_WD_VAL);

  always_comb begin
    gp_act_d = gp_act_q;
    gp_hi_d  = gp_hi_q;
    gp_lo_d  = gp_lo_q;
    ctl_d    = ctl_q;
    pin_d    = pin_q;
    val_d    = val_q;
    force_d  = 1'b0;
    stat_d   = stat_q;
    if (wr_evt) begin
      case (addr_q)
        ADDR_GP_ACT: gp_act_d = {7'h00, hwdata[GP_ACT_EN_BIT]};
        ADDR_GP_HI:  gp_hi_d  = hwdata[3:0];
        ADDR_GP_LO:  gp_lo_d  = hwdata[7:0];
        ADDR_WD_CTL: ctl_d    = hwdata[7:0] & CTL_RW_MASK;
        ADDR_WD_PIN: pin_d    = hwdata[5:0];
        ADDR_WD_VAL: val_d    = hwdata[7:0];
        default:     ctl_d    = ctl_q;
      endcase
    end
    if (ctl_wr && hwdata[CTL_FORCE_BIT]) begin
      force_d = 1'b1;
    end
    // Software clears status by writing 1; an expiry in the same cycle wins
    if (ctl_wr && hwdata[CTL_STAT_BIT]) begin
      stat_d = 1'b0;
    end
    if (expire) begin
      stat_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gp_act_q <= RST_GP_ACT;
      gp_hi_q  <= RST_GP_HI;
      gp_lo_q  <= RST_GP_LO;
      ctl_q    <= RST_WD_CTL;
      pin_q    <= RST_WD_PIN;
      val_q    <= RST_WD_VAL;
      force_q  <= 1'b0;
      stat_q   <= 1'b0;
    end else begin
      gp_act_q <= gp_act_d;
      gp_hi_q  <= gp_hi_d;
      gp_lo_q  <= gp_lo_d;
      ctl_q    <= ctl_d;
      pin_q    <= pin_d;
      val_q    <= val_d;
      force_q  <= force_d;
      stat_q   <= stat_d;
    end
  end

  assign base_addr              = {4'h0, gp_hi_q, gp_lo_q};
  assign game_port_base         = base_addr;
  assign game_port_enable       = gp_act_q[GP_ACT_EN_BIT];
  assign watchdog_timer_pin_loc = pin_q;
  assign watchdog_timer_timeout = stat_q;

  // ****************************************
  // Watchdog counter
  // ****************************************
  assign cir_pulse = consumer_infrared_irq & ~cir_q & ctl_q[CTL_CIR_EN_BIT];
  assign gp_pulse  = dp_q & io_q & (addr_q[17:2] == base_addr)
                     & ctl_q[CTL_GP_EN_BIT];
  assign reload    = cir_pulse | gp_pulse;
  assign unit_tick = ctl_q[CTL_UNIT_BIT] ? tk.sec_tick : tk.min_tick;
  assign expire    = force_q | ((state_q == WDGP_ST_RUN) & unit_tick
                     & (cnt_q == 9'h001));
  assign tk.restart = val_wr | ((state_q == WDGP_ST_RUN) & reload);

  // Stored value 0..255 stands for 1..256 units
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      WDGP_ST_IDLE: begin
        if (expire) begin
          state_d = WDGP_ST_EXPIRED;
        end else if (val_wr) begin
          state_d = WDGP_ST_RUN;
          cnt_d   = {1'b0, hwdata[7:0]} + 9'h001;
        end
      end
      WDGP_ST_RUN: begin
        // Software's write wins over a last tick in the same cycle
        if (val_wr && !force_q) begin
          cnt_d = {1'b0, hwdata[7:0]} + 9'h001;
        end else if (expire) begin
          state_d = WDGP_ST_EXPIRED;
          cnt_d   = 9'h000;
        end else if (reload) begin
          cnt_d = {1'b0, val_q} + 9'h001;
        end else if (unit_tick) begin
          cnt_d = cnt_q - 9'h001;
        end
      end
      WDGP_ST_EXPIRED: begin
        if (val_wr && !force_q) begin
          state_d = WDGP_ST_RUN;
          cnt_d   = {1'b0, hwdata[7:0]} + 9'h001;
        end
      end
      default: begin
        state_d = WDGP_ST_IDLE;
        cnt_d   = 9'h000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= WDGP_ST_IDLE;
      cnt_q   <= 9'h000;
      cir_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      cir_q   <= consumer_infrared_irq;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  cir_reload_a: assert property (
    (state_q == WDGP_ST_RUN) && cir_pulse && !expire && !val_wr
    |=> cnt_q == {1'b0, $past(val_q)} + 9'h001)
    else $error("infrared interrupt did not reload counter");

  cir_ignored_a: assert property (
    (state_q == WDGP_ST_RUN) && !ctl_q[CTL_CIR_EN_BIT] && !gp_pulse
    && !val_wr && !unit_tick && !force_q |=> cnt_q == $past(cnt_q))
    else $error("counter changed without a cause");

  gp_reload_a: assert property (
    (state_q == WDGP_ST_RUN) && dp_q && io_q && (addr_q[17:2] == base_addr)
    && ctl_q[CTL_GP_EN_BIT] && !expire
    |=> cnt_q == {1'b0, $past(val_q)} + 9'h001)
    else $error("game-port access did not reload counter");

  unit_minute_a: assert property (
    (state_q == WDGP_ST_RUN) && !ctl_q[CTL_UNIT_BIT] && tk.sec_tick
    && !tk.min_tick && !reload && !val_wr && !force_q
    |=> cnt_q == $past(cnt_q))
    else $error("minute unit counted a second");

  force_timeout_a: assert property (
    ctl_wr && hwdata[CTL_FORCE_BIT] |-> ##2 stat_q && (state_q == WDGP_ST_EXPIRED))
    else $error("forced time-out not issued");

  force_clear_a: assert property (
    force_q |=> !force_q)
    else $error("force bit did not clear");

  expiry_status_a: assert property (
    (state_q == WDGP_ST_RUN) && unit_tick && (cnt_q == 9'h001)
    |=> stat_q && watchdog_timer_timeout
    && (state_q == ($past(val_wr) ? WDGP_ST_RUN : WDGP_ST_EXPIRED)))
    else $error("expiry did not set status");

  value_load_a: assert property (
    val_wr && !force_q |=> (state_q == WDGP_ST_RUN)
    && cnt_q == {1'b0, $past(hwdata[7:0])} + 9'h001)
    else $error("value write did not start counter");

  base_high_a: assert property (
    wr_evt && (addr_q == ADDR_GP_HI)
    |=> game_port_base == {4'h0, $past(hwdata[3:0]), $past(gp_lo_q)})
    else $error("base high field not stored");

  reload_keeps_a: assert property (
    reload && !ctl_wr && !val_wr && !expire
    |=> stat_q == $past(stat_q) && val_q == $past(val_q))
    else $error("reload changed value or status");

  bus_wait_a: assert property (
    take && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait state");

  status_clear_a: assert property (
    ctl_wr && hwdata[CTL_STAT_BIT] && !expire |=> !stat_q)
    else $error("status write did not clear");

  unit_second_a: assert property (
    (state_q == WDGP_ST_RUN) && ctl_q[CTL_UNIT_BIT] && tk.sec_tick && (cnt_q > 9'h001)
    && !reload && !val_wr && !force_q |=> cnt_q == $past(cnt_q) - 9'h001)
    else $error("second unit did not count");

  activate_a: assert property (
    wr_evt && (addr_q == ADDR_GP_ACT) |=> game_port_enable == $past(hwdata[GP_ACT_EN_BIT]))
    else $error("activate bit not stored");

  pin_select_a: assert property (
    wr_evt && (addr_q == ADDR_WD_PIN) |=> watchdog_timer_pin_loc == $past(hwdata[5:0]))
    else $error("pin location not stored");

  base_low_a: assert property (
    wr_evt && (addr_q == ADDR_GP_LO) |=> game_port_base[7:0] == $past(hwdata[7:0]))
    else $error("base low byte not stored");

  val_store_a: assert property (
    val_wr |=> val_q == $past(hwdata[7:0]))
    else $error("time-out value not stored");

  force_seen_c:  cover property (ctl_wr && hwdata[CTL_FORCE_BIT] ##2 stat_q);
  value_load_c:  cover property (val_wr ##1 (state_q == WDGP_ST_RUN));
  count_out_c:   cover property ((state_q == WDGP_ST_RUN) ##1 (state_q == WDGP_ST_EXPIRED));
  cir_reload_c:  cover property ((state_q == WDGP_ST_RUN) && cir_pulse);
  gp_reload_c:   cover property ((state_q == WDGP_ST_RUN) && gp_pulse);

  logic unused_ok;
  assign unused_ok = &{1'b0, haddr[31:21], haddr[19:18], hsize, hwdata[31:8], rdata_d[31:8]};

endmodule // wdgp_watchdog_top
`default_nettype wire

// *** tb/wdgp_host_model.sv ***
// Host bus controller model: single-word AHB-Lite configuration and I/O cycles
`timescale 1ns/100ps
`default_nettype none
module wdgp_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // Waits are unbounded here; the bench watchdog cuts a hang short
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    // Released data bus shows the inverse so stale data never passes
    hwdata <= ~d;
  endtask
endmodule // wdgp_host_model
`default_nettype wire

// *** tb/wdgp_watchdog_top_tb.sv ***
// Self-checking testbench of the watchdog with game-port reload
`timescale 1ns/100ps
`default_nettype none
module wdgp_watchdog_top_tb;
  import wdgp_pkg::*;
  // Short second keeps the minute run near 240 cycles
  localparam int unsigned SC  = 4;
  localparam logic [31:0] IOA = {12'h001, 2'b00, 16'h03a5, 2'b00};

  typedef struct packed {
    logic [19:0] a;
    logic        w;
    logic [7:0]  d;
    logic [7:0]  e;
  } wdgp_row_t;

  logic        hclk, hresetn, hsel, hwrite, hready, hresp, irq, tmo, gp_en;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  pin;
  logic [15:0] gp_base;
  int          fails, check_count, cyc, t0;

  wdgp_row_t rows [13] = '{
    '{ADDR_GP_ACT, 1'b0, 8'h00, 8'h00},
    '{ADDR_GP_HI,  1'b0, 8'h00, 8'h02},
    '{ADDR_GP_LO,  1'b0, 8'h00, 8'h01},
    '{ADDR_WD_CTL, 1'b0, 8'h00, 8'h00},
    '{ADDR_WD_PIN, 1'b0, 8'h00, 8'h00},
    '{ADDR_WD_VAL, 1'b0, 8'h00, 8'h00},
    '{ADDR_GP_HI,  1'b1, 8'hff, 8'h0f},
    '{ADDR_GP_HI,  1'b1, 8'h03, 8'h03},
    '{ADDR_GP_LO,  1'b1, 8'ha5, 8'ha5},
    '{ADDR_WD_PIN, 1'b1, 8'hff, 8'h3f},
    '{ADDR_GP_ACT, 1'b1, 8'h01, 8'h01},
    '{ADDR_WD_CTL, 1'b1, 8'hf8, 8'h98},
    '{20'h00ff0,   1'b1, 8'hff, 8'h00}
  };

  wdgp_watchdog_top #(.SEC_CYCLES(SC)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .consumer_infrared_irq(irq), .watchdog_timer_timeout(tmo),
    .watchdog_timer_pin_loc(pin), .game_port_enable(gp_en), .game_port_base(gp_base)
  );

  wdgp_host_model host (
    .hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) cyc <= cyc + 1;

  // ****************************************
  // Check and bus helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    logic [31:0] x;
    host.xfer({12'h000, a}, 1'b1, {24'h0, d}, x);
  endtask

  task automatic rdc(input logic [19:0] a, input logic [7:0] e);
    logic [31:0] x;
    host.xfer({12'h000, a}, 1'b0, 32'h0, x);
    chk(x, {24'h0, e});
  endtask

  task automatic pulse();
    irq <= 1'b1;
    @(posedge hclk);
    irq <= 1'b0;
    @(posedge hclk);
  endtask

  task automatic expire(input int lo, input int hi);
    while (tmo !== 1'b1 && cyc - t0 <= hi) @(posedge hclk);
    chk({31'h0, tmo}, 32'h1);
    chk({31'h0, cyc - t0 >= lo}, 32'h1);
  endtask

  task automatic end_sim();
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    end_sim();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    hresetn = 1'b0;
    irq = 1'b0;
    fails = 0;
    check_count = 0;
    cyc = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    chk({16'h0, gp_base}, 32'h03a5);
    chk({26'h0, pin}, 32'h3f);
    chk({31'h0, gp_en}, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    t0 = cyc;
    wr(ADDR_WD_VAL, 8'h02);
    expire(3*SC-2, 3*SC+8);
    rdc(ADDR_WD_CTL, 8'h99);
    wr(ADDR_WD_CTL, 8'h99);
    rdc(ADDR_WD_CTL, 8'h98);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_WD_VAL, 8'h02);
      repeat (6) begin
        repeat (SC) @(posedge hclk);
        if (k == 0) pulse();
        else host.xfer(IOA, 1'b0, 32'h0, r);
        chk({31'h0, tmo}, 32'h0);
      end
      rdc(ADDR_WD_VAL, 8'h02);
      rdc(ADDR_WD_CTL, 8'h98);
    end
    chk(r, 32'hff);
    // Reload sources disabled: both kinds of hit must leave the count alone;
    // restart first so the old count cannot expire under the control write
    t0 = cyc;
    wr(ADDR_WD_VAL, 8'h04);
    wr(ADDR_WD_CTL, 8'h09);
    chk({31'h0, tmo}, 32'h0);
    repeat (2*SC) @(posedge hclk);
    pulse();
    host.xfer(IOA, 1'b0, 32'h0, r);
    expire(5*SC-2, 5*SC+8);
    wr(ADDR_WD_CTL, 8'h99);
    wr(ADDR_WD_VAL, 8'hff);
    t0 = cyc;
    wr(ADDR_WD_CTL, 8'h9a);
    expire(0, 8);
    rdc(ADDR_WD_CTL, 8'h99);
    wr(ADDR_WD_CTL, 8'h01);
    chk({31'h0, tmo}, 32'h0);
    t0 = cyc;
    wr(ADDR_WD_VAL, 8'h00);
    expire(60*SC-2, 60*SC+8);
    // Reset in mid-run
    wr(ADDR_WD_VAL, 8'h02);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    chk({15'h0, tmo, gp_base}, 32'h0201);
    chk({25'h0, pin, gp_en}, 32'h0);
    hresetn <= 1'b1;
    repeat (4*SC) @(posedge hclk);
    chk({31'h0, tmo}, 32'h0);
    rdc(ADDR_WD_CTL, 8'h00);
    end_sim();
  end
endmodule // wdgp_watchdog_top_tb
`default_nettype wire
